/* File: src/tmr_ev8_params.svh */
// constants for the 8-bit timer/event counter
`ifndef TMR_EV8_PARAMS_SVH
`define TMR_EV8_PARAMS_SVH
`define TMC_ADDR        16'hff53
`define MATCH_ADDR      16'hff54
`define CNT_ADDR        16'hff55
`define PORT_LATCH_ADDR 16'hff05
`define PDIR_ADDR       16'hff25
`define TMC_RUN_BIT     7
`define TMC_SRC_HI_BIT  2
`define TMC_SRC_LO_BIT  1
`define TMC_OE_BIT      0
`define TMC_RESET       8'h00
`define PDIR_RESET      8'hff
`define PDIR_FIXED      8'hf0
`define LATCH_RESET     8'h00
`define PRESCALE_DIV    32
`endif

/* File: src/tmr_ev8_pkg.sv */
// types for the 8-bit timer/event counter
package tmr_ev8_pkg;
  typedef enum logic [1:0] {
    src_sys    = 2'h0,
    src_div32  = 2'h1,
    src_rise   = 2'h2,
    src_fall   = 2'h3
  } count_src_t;

  typedef struct packed {
    logic       run;
    count_src_t src;
    logic       oe;
  } timer_mode_control_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } cpu_req_t;
endpackage

/* File: src/edge_sync.sv */
// pin synchroniser and edge detector producing one-cycle pulses
`timescale 1ns/1ps
module edge_sync (
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  input  wire logic pin_i,
  output logic      rise_o,
  output logic      fall_o
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic [2:0] sync_next;

  // s1 feeds only s2; edges are taken from s2/s3
  always_comb begin
    sync_next = {s2_reg, s1_reg, pin_i};
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      {s3_reg, s2_reg, s1_reg} <= sync_next;
    end
  end

  assign rise_o = s2_reg & ~s3_reg;
  assign fall_o = ~s2_reg & s3_reg;
endmodule

/* File: src/tmr_ev8.sv */
// 8-bit timer/event counter with square-wave output and port line control
//
// Operation
// - match clears counter, counts on, raises request
// - match value accepts 00h through ffh
// - source: clock, clock/32, pin rise, fall
// - event mode counts each selected pin edge
// - wave output toggles at every match
// - clearing run forces wave output low
// - wave output starts low when enabled
// - first period equals the later ones
// - direction resets ffh, upper nibble fixed
// - run 0 clears counter, 1 enables
// - edge source makes pin input, no wave
`timescale 1ns/1ps
`include "tmr_ev8_params.svh"
module tmr_ev8
  import tmr_ev8_pkg::*;
#(
  parameter int PRESCALE = `PRESCALE_DIV
) (
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  input  wire cpu_req_t   cpu_i,
  output logic [7:0]      rdata_o,
  output logic            match_interrupt_request_o,
  output logic            shared_port_line_o,
  output logic            shared_port_line_oe_o,
  input  wire logic       shared_port_line_i
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  timer_mode_control_t tmc_reg,   tmc_next;
  logic [7:0]          match_reg, match_next;
  logic [7:0]          cnt_reg,   cnt_next;
  logic [7:0]          pdir_reg,  pdir_next;
  logic [7:0]          latch_reg, latch_next;
  logic                wave_reg,  wave_next;
  logic                irq_reg,   irq_next;
  logic [7:0]          rdata_reg, rdata_next;
  logic [4:0]          pre_reg,   pre_next;
  logic                tick;
  logic                hit;
  logic                pin_rise;
  logic                pin_fall;
  logic                ext_src;

  // two sync stages plus the edge flop: an event counts two to three clocks late
  edge_sync u_edge (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (shared_port_line_i),
    .rise_o    (pin_rise),
    .fall_o    (pin_fall)
  );

  // ----------------------------------------------------------------
  // count source and compare
  // ----------------------------------------------------------------
  assign ext_src = tmc_reg.src[1];

  // prescaler wraps at PRESCALE - 1 so a short prescale keeps its own period;
  // it is held at zero while stopped, so every start sees the same phase
  always_comb begin
    if (!tmc_reg.run || pre_reg == 5'(PRESCALE - 1)) begin
      pre_next = 5'h00;
    end else begin
      pre_next = pre_reg + 5'h01;
    end
  end

  always_comb begin
    unique case (tmc_reg.src)
      src_sys:   tick = 1'b1;
      src_div32: tick = (pre_reg == 5'(PRESCALE - 1));
      src_rise:  tick = pin_rise;
      src_fall:  tick = pin_fall;
    endcase
    // full 8-bit compare, so 00h matches on every pulse
    hit = tmc_reg.run && tick && (cnt_reg == match_reg);
  end

  // ----------------------------------------------------------------
  // registers and bus
  // ----------------------------------------------------------------
  always_comb begin
    tmc_next   = tmc_reg;
    match_next = match_reg;
    pdir_next  = pdir_reg;
    latch_next = latch_reg;
    rdata_next = rdata_reg;
    cnt_next   = cnt_reg;
    wave_next  = wave_reg;
    // the counter address is read only; a write there falls to the default and is dropped
    // a match write while running may hit at once; software stops the counter first
    if (cpu_i.wr) begin
      unique case (cpu_i.addr)
        `TMC_ADDR:        tmc_next   = {cpu_i.wdata[`TMC_RUN_BIT],
                                        cpu_i.wdata[`TMC_SRC_HI_BIT:`TMC_SRC_LO_BIT],
                                        cpu_i.wdata[`TMC_OE_BIT]};
        `MATCH_ADDR:      match_next = cpu_i.wdata;
        `PDIR_ADDR:       pdir_next  = cpu_i.wdata | `PDIR_FIXED;
        `PORT_LATCH_ADDR: latch_next = cpu_i.wdata;
        default:          ;
      endcase
    end
    if (cpu_i.rd) begin
      unique case (cpu_i.addr)
        `TMC_ADDR:        rdata_next = {tmc_reg.run, 4'h0, tmc_reg.src, tmc_reg.oe};
        `MATCH_ADDR:      rdata_next = match_reg;
        `CNT_ADDR:        rdata_next = cnt_reg;
        `PDIR_ADDR:       rdata_next = pdir_reg;
        `PORT_LATCH_ADDR: rdata_next = latch_reg;
        default:          rdata_next = 8'h00;
      endcase
    end
    // counting; the prescaler restarts from zero with run, so the first period is exact
    if (!tmc_reg.run) begin
      cnt_next = 8'h00;
    end else if (hit) begin
      cnt_next = 8'h00;
    end else if (tick) begin
      cnt_next = cnt_reg + 8'h01;
    end
    // wave output
    // a run clear lands in the wave register one clock after the write is taken
    if (!tmc_reg.run || !tmc_reg.oe || ext_src) begin
      wave_next = 1'b0;
    end else if (hit) begin
      wave_next = ~wave_reg;
    end
    irq_next = hit;
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tmc_reg   <= timer_mode_control_t'(`TMC_RESET);
      match_reg <= 8'h00;
      cnt_reg   <= 8'h00;
      pdir_reg  <= `PDIR_RESET;
      latch_reg <= `LATCH_RESET;
      wave_reg  <= 1'b0;
      irq_reg   <= 1'b0;
      rdata_reg <= 8'h00;
      pre_reg   <= 5'h00;
    end else begin
      tmc_reg   <= tmc_next;
      match_reg <= match_next;
      cnt_reg   <= cnt_next;
      pdir_reg  <= pdir_next;
      latch_reg <= latch_next;
      wave_reg  <= wave_next;
      irq_reg   <= irq_next;
      rdata_reg <= rdata_next;
      pre_reg   <= pre_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // the request is a registered pulse set on the same edge that clears the counter
  assign match_interrupt_request_o = irq_reg;
  assign rdata_o                   = rdata_reg;
  // edge source keeps the pin an input regardless of direction
  assign shared_port_line_oe_o     = ~pdir_reg[0] & ~ext_src;
  assign shared_port_line_o        = tmc_reg.oe ? (wave_reg | latch_reg[0]) : latch_reg[0];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_match_clears: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    hit |=> (cnt_reg == 8'h00) && irq_reg)
    else $error("match did not clear counter or raise request");
  a_irq_cause: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    irq_reg |-> $past(cnt_reg) == $past(match_reg))
    else $error("request without match");
  a_stop_clears: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !tmc_reg.run |=> cnt_reg == 8'h00)
    else $error("stopped counter not zero");
  a_stop_wave_low: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !tmc_reg.run |=> !wave_reg)
    else $error("wave not low while stopped");
  a_wave_toggle: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    hit && tmc_reg.oe && !ext_src && $stable(tmc_reg) |=> wave_reg != $past(wave_reg))
    else $error("wave did not toggle on match");
  a_wave_oe_low: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    $rose(tmc_reg.oe) |-> !wave_reg)
    else $error("wave not low at enable");
  a_ext_no_drive: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ext_src |-> !shared_port_line_oe_o && !wave_reg)
    else $error("pin driven in event mode");
  a_count_step: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    tmc_reg.run && tick && !hit && $stable(tmc_reg) |=> cnt_reg == $past(cnt_reg) + 8'h01)
    else $error("counter did not step");
  a_zero_match: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    tmc_reg.run && tick && match_reg == 8'h00 |=> irq_reg)
    else $error("zero match missed pulse");
  a_pdir_fixed: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    pdir_reg[7:4] == 4'hf)
    else $error("direction upper bits not one");
  a_pre_range: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    pre_reg <= 5'(PRESCALE - 1))
    else $error("prescaler out of range");
  a_event_quiet: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ext_src && tmc_reg.run && !tick |=> cnt_reg == $past(cnt_reg))
    else $error("counter moved without a valid edge");

  c_match: cover property (@(posedge mclk_i) disable iff (sys_rst_i) hit);
  c_wave_high: cover property (@(posedge mclk_i) disable iff (sys_rst_i) $rose(wave_reg));
  c_event_hit: cover property (@(posedge mclk_i) disable iff (sys_rst_i) hit && ext_src);
  c_div_hit: cover property (@(posedge mclk_i) disable iff (sys_rst_i) hit && tmc_reg.src == src_div32);
  c_zero_hit: cover property (@(posedge mclk_i) disable iff (sys_rst_i) hit && match_reg == 8'h00);
endmodule

/* File: tb/pin_source.sv */
// event source and load on the shared port line
`timescale 1ns/1ps
module pin_source (
  input  wire logic pin_drv_i,
  input  wire logic pin_oe_i,
  input  wire logic ev_i,
  output logic      line_o
);
  // the port owns the line while it drives, otherwise the event source does
  assign line_o = pin_oe_i ? pin_drv_i : ev_i;
endmodule

/* File: tb/tmr_ev8_tb.sv */
// self-checking bench for the 8-bit timer/event counter
`timescale 1ns/1ps
`include "tmr_ev8_params.svh"
module tmr_ev8_tb;
  import tmr_ev8_pkg::*;
  localparam int PS = 4;
  logic       mclk_i = 0, sys_rst_i = 1, ev = 0, pin, irq, po, poe;
  cpu_req_t   cpu = '0;
  logic [7:0] rd;
  int         seed = 32'h309b, err_count = 0, compares = 0, cyc = 0, last = 0, per = 0, irq_n = 0, n, m;
  always #25 mclk_i = ~mclk_i;
  tmr_ev8 #(.PRESCALE(PS)) uut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .cpu_i(cpu), .rdata_o(rd),
    .match_interrupt_request_o(irq), .shared_port_line_o(po), .shared_port_line_oe_o(poe),
    .shared_port_line_i(pin));
  pin_source model (.pin_drv_i(po), .pin_oe_i(poe), .ev_i(ev), .line_o(pin));
  always @(posedge mclk_i) begin
    cyc++;
    if (irq === 1'b1) begin
      per = cyc - last;
      last = cyc;
      irq_n++;
    end
  end
  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(logic [15:0] a, logic [7:0] d);
    @(posedge mclk_i) #1 cpu = '{1'b1, 1'b0, a, d};
    @(posedge mclk_i) #1 cpu = '0;
  endtask
  task automatic rd_chk(logic [15:0] a, logic [7:0] e, string what);
    @(posedge mclk_i) #1 cpu = '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk_i) #1 cpu = '0;
    chk(what, e, rd);
  endtask
  // bounded wait for k requests; the count seen is checked against k
  task automatic wait_irq(int k);
    int t0;
    t0 = irq_n;
    for (int i = 0; i < 3000 && irq_n < t0 + k; i++) begin
      @(posedge mclk_i);
      #1;
    end
    chk("irq wait", 16'(k), 16'(irq_n - t0));
  endtask
  task automatic pulses(int k);
    for (int i = 0; i < k; i++) begin
      repeat (3) @(posedge mclk_i);
      #1 ev = 1;
      repeat (3 + ($random(seed) & 3)) @(posedge mclk_i);
      #1 ev = 0;
    end
    repeat (6) @(posedge mclk_i);
  endtask
  task automatic timer(logic [1:0] src, logic [7:0] mv, int exp);
    int n0;
    wr_reg(`TMC_ADDR, 8'h00);
    wr_reg(`TMC_ADDR, {5'h00, src, 1'b1});
    wr_reg(`MATCH_ADDR, mv);
    chk("wave idle", 1'b0, po);
    chk("drive en", 1'b1, poe);
    n0 = irq_n;
    wr_reg(`TMC_ADDR, {5'h10, src, 1'b1});
    wait_irq(3);
    chk("period", exp[15:0], per[15:0]);
    if (mv != 0) chk("wave", 16'((irq_n - n0) & 1), po);
    wr_reg(`TMC_ADDR, {5'h00, src, 1'b1});
    // the wave register drops one clock after the run clear is taken
    @(posedge mclk_i) #1;
    chk("wave off", 1'b0, po);
    rd_chk(`CNT_ADDR, 8'h00, "count cleared");
    $display("timer test src %0d match %h done", src, mv);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #2000000;
    err_count++;
    summarize;
  end
  initial begin
    repeat (6) @(posedge mclk_i);
    #1 sys_rst_i = 0;
    rd_chk(`PDIR_ADDR, 8'hff, "dir reset");
    rd_chk(`TMC_ADDR, 8'h00, "mode reset");
    rd_chk(16'hff60, 8'h00, "unmapped");
    wr_reg(`PDIR_ADDR, 8'h00);
    wr_reg(`PORT_LATCH_ADDR, 8'h00);
    rd_chk(`PDIR_ADDR, 8'hf0, "dir fixed");
    rd_chk(`PORT_LATCH_ADDR, 8'h00, "latch");
    $display("reset test done");
    timer(2'h0, 8'h00, 1);
    timer(2'h0, 8'hff, 256);
    m = $random(seed) & 63;
    timer(2'h0, m[7:0], m + 1);
    m = $random(seed) & 63;
    timer(2'h1, m[7:0], (m + 1) * PS);
    // direction left at output: an edge source must still keep the pin undriven
    for (int s = 2; s < 4; s++) begin
      wr_reg(`TMC_ADDR, 8'h00);
      wr_reg(`TMC_ADDR, {5'h00, s[1:0], 1'b1});
      wr_reg(`MATCH_ADDR, 8'hff);
      wr_reg(`TMC_ADDR, {5'h10, s[1:0], 1'b1});
      chk("edge drive", 2'b00, {poe, po});
      n = ($random(seed) & 15) + 1;
      pulses(n);
      rd_chk(`CNT_ADDR, n[7:0], "events");
      $display("event test src %0d done", s);
    end
    wr_reg(`PDIR_ADDR, 8'h01);
    wr_reg(`TMC_ADDR, 8'h00);
    wr_reg(`TMC_ADDR, 8'h04);
    wr_reg(`MATCH_ADDR, 8'h00);
    wr_reg(`TMC_ADDR, 8'h84);
    m = irq_n;
    pulses(n);
    chk("event irqs", n[15:0], 16'(irq_n - m));
    $display("single event test done");
    summarize;
  end
endmodule
